// ---- rtl/fpx_pkg.sv ----
package fpx_pkg;
   // Instruction fields
   localparam int          OPC_MSB = 31;
   localparam int          OPC_LSB = 26;
   localparam int          FN_MSB  = 15;
   localparam int          FN_LSB  = 5;
   localparam int          FW_MSB  = 25;
   localparam int          SWC_BIT = 10;
   localparam logic [5:0]  OPC_FLT_INDEP = 6'h17;
   localparam logic [5:0]  OPC_IEEE      = 6'h16;
   localparam logic [5:0]  OPC_LEGACY    = 6'h15;
   localparam logic [5:0]  OPC_FIRMWARE  = 6'h00;
   localparam logic [5:0]  OPC_MISC      = 6'h18;
   localparam logic [5:0]  OPC_INT_LOGIC = 6'h11;
   localparam logic [10:0] FN_SIGN_COPY     = 11'h020;
   localparam logic [10:0] FN_NEG_SIGN_COPY = 11'h021;
   localparam logic [10:0] FN_SIGN_EXP_COPY = 11'h022;
   localparam logic [10:0] FN_CTRL_WRITE    = 11'h024;
   localparam logic [10:0] FN_CTRL_READ     = 11'h025;
   localparam logic [10:0] FN_LONG_TO_QUAD  = 11'h010;
   localparam logic [10:0] FN_QTOL_NONE     = 11'h030;
   localparam logic [10:0] FN_QTOL_V        = 11'h130;
   localparam logic [10:0] FN_QTOL_SV       = 11'h530;
   localparam logic [10:0] FN_FCMOV_EQ      = 11'h02A;
   localparam logic [10:0] FN_FCMOV_LT      = 11'h02C;
   localparam logic [10:0] FN_FCMOV_GE      = 11'h02D;
   localparam logic [10:0] FN_FCMOV_LE      = 11'h02E;
   localparam logic [10:0] FN_FCMOV_GT      = 11'h02F;
   localparam logic [10:0] FN_ARCH_MASK     = 11'h061;
   localparam logic [5:0]  SUB_ADD_S  = 6'h00;
   localparam logic [5:0]  SUB_SUB_S  = 6'h01;
   localparam logic [5:0]  SUB_ADD_T  = 6'h20;
   localparam logic [5:0]  SUB_SUB_T  = 6'h21;
   localparam logic [5:0]  SUB_ROOT_S = 6'h0B;
   localparam logic [5:0]  SUB_ROOT_T = 6'h2B;
   localparam logic [5:0]  SUB_ROOT_F = 6'h0A;
   localparam logic [5:0]  SUB_ROOT_G = 6'h2A;
   localparam logic [25:0] FW_HALT   = 26'h0000000;
   localparam logic [25:0] FW_DRAIN_ABORTS_CALL = 26'h0000002;
   localparam logic [25:0] FW_IMB    = 26'h0000086;
   localparam logic [15:0] MISC_TRAP_BARRIER = 16'h0000;
   localparam int          ARCH_PRECISE_BIT  = 9;
   // Exception order in every 5-bit vector
   localparam int NUM_EXC = 5;
   localparam int EXC_INV = 0;
   localparam int EXC_DZE = 1;
   localparam int EXC_OVF = 2;
   localparam int EXC_UNF = 3;
   localparam int EXC_INE = 4;
   localparam int SUM_DENORM = 5;
   // fp_control_register layout
   localparam int CTL_DNZ      = 0;
   localparam int CTL_UNDERFLOW_TO_ZERO_BIT     = 1;
   localparam int CTL_DIS_LSB  = 2;
   localparam int CTL_STAT_LSB = 8;
   localparam logic [31:0] CTL_RESET = 32'h0000_0000;
   localparam logic [31:0] CTL_WMASK = 32'h0000_1F7F;
   // APB map
   localparam int         ADDR_W         = 8;
   localparam logic [7:0] ADDR_CTRL      = 8'h00;
   localparam logic [7:0] ADDR_EXCEPTION_SUMMARY_REGISTER   = 8'h04;
   localparam logic [7:0] ADDR_IRQ_STAT  = 8'h08;
   localparam logic [7:0] ADDR_IRQ_MASK  = 8'h0C;
   localparam logic [7:0] ADDR_ARCH_MASK = 8'h10;
   localparam int IRQ_W      = 3;
   localparam int IRQ_ARITH  = 0;
   localparam int IRQ_DENORM = 1;
   localparam int IRQ_HALT   = 2;
   // Double-format fields
   localparam int EXP_MSB   = 62;
   localparam int EXP_LSB   = 52;
   localparam int FRAC_MSB  = 51;
   localparam int QUIET_BIT = 51;
   localparam int SIGN_BIT  = 63;
   localparam logic [63:0] CANON_QNAN = 64'h7FF8_0000_0000_0000;
   localparam logic [62:0] INF_MAG    = 63'h7FF0_0000_0000_0000;
   localparam logic [62:0] MAX_MAG    = 63'h7FEF_FFFF_FFFF_FFFF;
   localparam logic [63:0] QUIET_MASK = 64'h0008_0000_0000_0000;
   localparam logic [63:0] POS_ZERO   = 64'h0000_0000_0000_0000;

   typedef struct packed {
      logic valid;
      logic flt_indep;
      logic sign_copy;
      logic ctrl_write;
      logic ctrl_read;
      logic fcmov;
      logic cvt;
      logic arith;
      logic sqrt_hw;
      logic swc;
      logic halt;
      logic drain_aborts_call;
      logic instruction_memory_barrier_call;
      logic priv_fault;
      logic issue_drop;
      logic arch_mask;
   } fpx_decode_t;

   typedef struct packed {
      logic        valid;
      logic        arith;
      logic        add_sub;
      logic        subtract;
      logic        swc;
      logic        ctrl_write;
      logic        halt;
      logic        ovf_to_max;
      logic [4:0]  trap_en;
      logic [4:0]  dp_exc;
      logic [63:0] op_a;
      logic [63:0] op_b;
      logic [63:0] dp_result;
      logic [31:0] ctrl_wdata;
   } fpx_retire_t;

   typedef struct packed {
      logic        valid;
      logic        trap;
      logic        denorm_trap;
      logic [4:0]  trap_exc;
      logic [63:0] value;
   } fpx_result_t;
endpackage

// ---- rtl/fpx_unit.sv ----
// Contract
// - Opcode 17 hex, 11-bit function selects operation
// - Function 020 sign copy, 024/025 control write/read
// - Firmware calls: halt privileged, barrier unprivileged
// - Precise exceptions, mask bit 9, barriers dropped
// - NaNs propagate; canonical quiet NaN when none
// - Hardware square root, four formats
// - Zero-denormal bit plus completion: no denormal trap
// - Zero-denormal bit clear: unmaskable denormal trap
// - Copies, moves, control moves never trap
// - Disable bit plus completion suppresses trap
// - Substitute: signed infinity, largest finite, quiet NaN
// - Underflow writes positive zero, never denormal
// - Every exception sets its sticky status bit
// - Status cleared only by control write
// - Enabled, undisabled trap recorded in summary
// - Input-operand trap beats result trap
// - Add/subtract special inputs give fixed results; code does so only with completion
//
// The APB slave port and the register addresses were left to the implementer.
`timescale 1ns/100ps
module fpx_unit (
   input  wire logic                      pclk,        // Core clock
   input  wire logic                      presetn,     // Async reset, active low
   input  wire logic                      psel,        // APB select
   input  wire logic                      penable,     // APB access phase
   input  wire logic                      pwrite,      // APB direction
   input  wire logic [31:0]               paddr,       // APB byte address
   input  wire logic [31:0]               pwdata,      // APB write data
   output logic      [31:0]               prdata,      // APB read data
   output logic                           pready,      // APB ready
   output logic                           pslverr,     // APB error
   output logic                           irq,         // Level interrupt
   input  wire logic                      issue_valid, // Instruction offered
   input  wire logic [31:0]               issue_instr, // Instruction word
   input  wire logic                      kernel_mode, // Privileged context
   output fpx_pkg::fpx_decode_t           dec,         // Registered decode
   input  wire fpx_pkg::fpx_retire_t      ret,         // Retiring instruction
   output fpx_pkg::fpx_result_t           res,         // Registered result
   output logic      [31:0]               ctrl_value   // Control register copy
);
   // Decode
   logic [5:0]  opc;
   logic [10:0] fn;
   logic [25:0] fw_fn;
   logic        is_indep;
   logic        is_fp_arith;
   logic        d_sign_copy;
   logic        d_fcmov;
   logic        d_cvt;
   logic        d_sqrt;
   logic        d_halt;
   logic        d_fw;
   fpx_pkg::fpx_decode_t dec_d;
   fpx_pkg::fpx_decode_t dec_q;

   assign opc      = issue_instr[fpx_pkg::OPC_MSB:fpx_pkg::OPC_LSB];
   assign fn       = issue_instr[fpx_pkg::FN_MSB:fpx_pkg::FN_LSB];
   assign fw_fn    = issue_instr[fpx_pkg::FW_MSB:0];
   assign is_indep = (opc == fpx_pkg::OPC_FLT_INDEP);
   assign is_fp_arith = (opc == fpx_pkg::OPC_IEEE) || (opc == fpx_pkg::OPC_LEGACY);
   assign d_sign_copy = is_indep && ((fn == fpx_pkg::FN_SIGN_COPY)
                        || (fn == fpx_pkg::FN_NEG_SIGN_COPY)
                        || (fn == fpx_pkg::FN_SIGN_EXP_COPY));
   assign d_fcmov = is_indep && ((fn == fpx_pkg::FN_FCMOV_EQ) || (fn == fpx_pkg::FN_FCMOV_LT)
                    || (fn == fpx_pkg::FN_FCMOV_GE) || (fn == fpx_pkg::FN_FCMOV_LE)
                    || (fn == fpx_pkg::FN_FCMOV_GT));
   assign d_cvt = is_indep && ((fn == fpx_pkg::FN_LONG_TO_QUAD) || (fn == fpx_pkg::FN_QTOL_NONE)
                  || (fn == fpx_pkg::FN_QTOL_V) || (fn == fpx_pkg::FN_QTOL_SV));
   assign d_sqrt = ((opc == fpx_pkg::OPC_IEEE) && ((fn[5:0] == fpx_pkg::SUB_ROOT_S)
                   || (fn[5:0] == fpx_pkg::SUB_ROOT_T)))
                   || ((opc == fpx_pkg::OPC_LEGACY) && ((fn[5:0] == fpx_pkg::SUB_ROOT_F)
                   || (fn[5:0] == fpx_pkg::SUB_ROOT_G)));
   assign d_fw   = (opc == fpx_pkg::OPC_FIRMWARE);
   assign d_halt = d_fw && (fw_fn == fpx_pkg::FW_HALT);

   always_comb begin
      dec_d            = '0;
      dec_d.valid      = issue_valid;
      dec_d.flt_indep  = is_indep;
      dec_d.sign_copy  = d_sign_copy;
      dec_d.ctrl_write = is_indep && (fn == fpx_pkg::FN_CTRL_WRITE);
      dec_d.ctrl_read  = is_indep && (fn == fpx_pkg::FN_CTRL_READ);
      dec_d.fcmov      = d_fcmov;
      dec_d.cvt        = d_cvt;
      dec_d.arith      = is_fp_arith;
      dec_d.sqrt_hw    = d_sqrt;
      dec_d.swc        = is_fp_arith && fn[fpx_pkg::SWC_BIT];
      dec_d.halt       = d_halt;
      dec_d.drain_aborts_call     = d_fw && (fw_fn == fpx_pkg::FW_DRAIN_ABORTS_CALL);
      dec_d.instruction_memory_barrier_call        = d_fw && (fw_fn == fpx_pkg::FW_IMB);
      dec_d.priv_fault = d_halt && !kernel_mode;
      dec_d.issue_drop = (opc == fpx_pkg::OPC_MISC)
                         && (issue_instr[15:0] == fpx_pkg::MISC_TRAP_BARRIER);
      dec_d.arch_mask  = (opc == fpx_pkg::OPC_INT_LOGIC) && (fn == fpx_pkg::FN_ARCH_MASK);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dec_q <= '0;
      end else begin
         dec_q <= dec_d;
      end
   end
   assign dec = dec_q;

   // Operand classes
   logic a_maxe, b_maxe, a_fnz, b_fnz, a_nan, b_nan, a_snan, b_snan;
   logic a_inf, b_inf, a_den, b_den;
   assign a_maxe = &ret.op_a[fpx_pkg::EXP_MSB:fpx_pkg::EXP_LSB];
   assign b_maxe = &ret.op_b[fpx_pkg::EXP_MSB:fpx_pkg::EXP_LSB];
   assign a_fnz  = |ret.op_a[fpx_pkg::FRAC_MSB:0];
   assign b_fnz  = |ret.op_b[fpx_pkg::FRAC_MSB:0];
   assign a_nan  = a_maxe && a_fnz;
   assign b_nan  = b_maxe && b_fnz;
   assign a_snan = a_nan && !ret.op_a[fpx_pkg::QUIET_BIT];
   assign b_snan = b_nan && !ret.op_b[fpx_pkg::QUIET_BIT];
   assign a_inf  = a_maxe && !a_fnz;
   assign b_inf  = b_maxe && !b_fnz;
   assign a_den  = !(|ret.op_a[fpx_pkg::EXP_MSB:fpx_pkg::EXP_LSB]) && a_fnz;
   assign b_den  = !(|ret.op_b[fpx_pkg::EXP_MSB:fpx_pkg::EXP_LSB]) && b_fnz;

   // Control register and exception policy
   logic [31:0] ctrl_q, ctrl_d;
   logic [5:0]  sum_q, sum_d;
   logic [4:0]  dis_bits, dis_eff, exc, trap_exc, spec_exc, stat_bits;
   logic        retire, denormals_to_zero_bit, eff_sub, any_snan, any_nan, inf_inf, any_inf, special;
   logic        den_trap;
   logic [63:0] nan_src, inf_res, spec_val, sub_val, res_val;
   fpx_pkg::fpx_result_t res_q;

   assign retire   = ret.valid;
   assign denormals_to_zero_bit      = ctrl_q[fpx_pkg::CTL_DNZ];
   assign dis_bits = ctrl_q[fpx_pkg::CTL_DIS_LSB +: fpx_pkg::NUM_EXC];
   assign stat_bits = ctrl_q[fpx_pkg::CTL_STAT_LSB +: fpx_pkg::NUM_EXC];
   assign dis_eff  = ret.swc ? dis_bits : '0;
   assign eff_sub  = ret.op_a[fpx_pkg::SIGN_BIT] ^ ret.op_b[fpx_pkg::SIGN_BIT] ^ ret.subtract;
   assign any_snan = a_snan || b_snan;
   assign any_nan  = a_nan || b_nan;
   assign inf_inf  = a_inf && b_inf && eff_sub;
   assign any_inf  = a_inf || b_inf;
   assign special  = ret.arith && ret.add_sub && ret.swc && (any_nan || any_inf);
   assign nan_src  = a_nan ? ret.op_a : ret.op_b;
   assign inf_res  = a_inf ? ret.op_a
                   : {ret.op_b[fpx_pkg::SIGN_BIT] ^ ret.subtract, ret.op_b[62:0]};
   assign spec_val = any_nan ? (nan_src | fpx_pkg::QUIET_MASK)
                   : inf_inf ? fpx_pkg::CANON_QNAN : inf_res;
   assign spec_exc = (any_snan || (!any_nan && inf_inf)) ? 5'h01 : 5'h00;
   assign exc      = !ret.arith ? '0 : (special ? spec_exc : ret.dp_exc);
   // Denormal input trap ignores every disable bit
   assign den_trap = ret.arith && (a_den || b_den) && !(denormals_to_zero_bit && ret.swc);
   assign trap_exc = den_trap ? '0 : (exc & ret.trap_en & ~dis_eff);

   // Nontrapping substitutes; underflow flushes even when it traps
   always_comb begin
      if (exc[fpx_pkg::EXC_UNF]) begin
         sub_val = fpx_pkg::POS_ZERO;
      end else if (exc[fpx_pkg::EXC_INV] && dis_eff[fpx_pkg::EXC_INV]) begin
         sub_val = fpx_pkg::CANON_QNAN;
      end else if (exc[fpx_pkg::EXC_DZE] && dis_eff[fpx_pkg::EXC_DZE]) begin
         sub_val = {ret.dp_result[fpx_pkg::SIGN_BIT], fpx_pkg::INF_MAG};
      end else if (exc[fpx_pkg::EXC_OVF] && dis_eff[fpx_pkg::EXC_OVF]) begin
         sub_val = {ret.dp_result[fpx_pkg::SIGN_BIT],
                    ret.ovf_to_max ? fpx_pkg::MAX_MAG : fpx_pkg::INF_MAG};
      end else begin
         sub_val   = ret.dp_result;
      end
   end
   assign res_val = special ? spec_val : sub_val;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         res_q <= '0;
      end else begin
         res_q.valid       <= retire;
         res_q.trap        <= retire && (den_trap || (|trap_exc));
         res_q.denorm_trap <= retire && den_trap;
         res_q.trap_exc    <= retire ? trap_exc : '0;
         if (retire) begin
            res_q.value <= res_val;
         end
      end
   end
   assign res = res_q;

   // APB slave: one access cycle, data latched in the setup cycle
   logic        setup_ph, wr_acc, rd_acc;
   logic        sel_ctrl, sel_sum, sel_istat, sel_imask, sel_arch, mapped;
   logic [31:0] rd_val, prdata_q;
   logic        perr_q;
   logic [2:0]  istat_q, istat_d, imask_q, irq_evt, rd_clr;
   logic [7:0]  addr;

   assign addr      = paddr[fpx_pkg::ADDR_W-1:0];
   assign setup_ph  = psel && !penable;
   assign wr_acc    = psel && penable && pwrite;
   assign rd_acc    = psel && penable && !pwrite;
   assign sel_ctrl  = (paddr[31:fpx_pkg::ADDR_W] == '0) && (addr == fpx_pkg::ADDR_CTRL);
   assign sel_sum   = (paddr[31:fpx_pkg::ADDR_W] == '0) && (addr == fpx_pkg::ADDR_EXCEPTION_SUMMARY_REGISTER);
   assign sel_istat = (paddr[31:fpx_pkg::ADDR_W] == '0) && (addr == fpx_pkg::ADDR_IRQ_STAT);
   assign sel_imask = (paddr[31:fpx_pkg::ADDR_W] == '0) && (addr == fpx_pkg::ADDR_IRQ_MASK);
   assign sel_arch  = (paddr[31:fpx_pkg::ADDR_W] == '0) && (addr == fpx_pkg::ADDR_ARCH_MASK);
   assign mapped    = sel_ctrl || sel_sum || sel_istat || sel_imask || sel_arch;
   assign rd_val    = sel_ctrl  ? ctrl_q
                    : sel_sum   ? {26'h0, sum_q}
                    : sel_istat ? {29'h0, istat_q}
                    : sel_imask ? {29'h0, imask_q}
                    : sel_arch  ? (32'h1 << fpx_pkg::ARCH_PRECISE_BIT) : 32'h0;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q <= '0;
         perr_q   <= 1'b0;
      end else if (setup_ph) begin
         prdata_q <= pwrite ? 32'h0 : rd_val;
         perr_q   <= !mapped;
      end
   end
   assign prdata  = prdata_q;
   assign pslverr = penable && perr_q;
   assign pready  = penable;

   // Status bits change only by control writes or by retiring exceptions
   always_comb begin
      ctrl_d = ctrl_q;
      if (wr_acc && sel_ctrl) begin
         ctrl_d = pwdata & fpx_pkg::CTL_WMASK;
      end
      if (retire && ret.ctrl_write) begin
         ctrl_d = ret.ctrl_wdata & fpx_pkg::CTL_WMASK;
      end
      if (retire) begin
         ctrl_d[fpx_pkg::CTL_STAT_LSB +: fpx_pkg::NUM_EXC] =
            ctrl_d[fpx_pkg::CTL_STAT_LSB +: fpx_pkg::NUM_EXC] | exc;
      end
   end

   // Summary is write-one-to-clear; a new trap wins over the clear
   assign sum_d = ((wr_acc && sel_sum) ? (sum_q & ~pwdata[5:0]) : sum_q)
                  | (retire ? {den_trap, trap_exc} : 6'h00);
   assign irq_evt = {retire && ret.halt, retire && den_trap, retire && (|trap_exc)};
   // Only bits already shown to the reader are cleared
   assign rd_clr  = (rd_acc && sel_istat) ? prdata_q[2:0] : 3'h0;
   assign istat_d = (istat_q & ~rd_clr) | irq_evt;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q  <= fpx_pkg::CTL_RESET;
         sum_q   <= '0;
         istat_q <= '0;
         imask_q <= '0;
      end else begin
         ctrl_q  <= ctrl_d;
         sum_q   <= sum_d;
         istat_q <= istat_d;
         if (wr_acc && sel_imask) begin
            imask_q <= pwdata[2:0];
         end
      end
   end
   assign ctrl_value = ctrl_q;
   assign irq        = |(istat_q & imask_q);

   // Checks
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence ret_arith_s;
      ret.valid && ret.arith;
   endsequence
   sequence arch_read_s;
      setup_ph && !pwrite && sel_arch;
   endsequence

   halt_priv_a: assert property (issue_valid && d_halt && !kernel_mode
      |=> dec.halt && dec.priv_fault)
      else $error("halt outside kernel not flagged");
   indep_decode_a: assert property (dec_d.ctrl_read |-> opc == 6'h17 && fn == 11'h025)
      else $error("control read decoded off its code");
   barrier_drop_a: assert property (issue_valid && opc == 6'h18 && issue_instr[15:0] == 16'h0
      |=> dec.issue_drop)
      else $error("trap barrier not dropped");
   arch_bit_a: assert property (arch_read_s |=> prdata[9] && !pslverr)
      else $error("arch mask bit 9 missing");
   unf_zero_a: assert property (ret_arith_s ##0 exc[3] |=> res.value == 64'h0)
      else $error("underflow result not +0");
   stat_hold_a: assert property (($past(ctrl_q[12:8]) & ~ctrl_q[12:8]) != 5'h0
      |-> $past(wr_acc && sel_ctrl) || $past(ret.valid && ret.ctrl_write))
      else $error("status bit cleared without control write");
   stat_set_a: assert property (ret_arith_s ##0 !ret.ctrl_write
      |=> (ctrl_q[12:8] & $past(exc)) == $past(exc))
      else $error("sticky status not set");
   den_prio_a: assert property (ret_arith_s ##0 (a_den && !(denormals_to_zero_bit && ret.swc))
      |=> res.trap && res.denorm_trap && res.trap_exc == 5'h0)
      else $error("denormal trap lost priority");
   dnz_avoid_a: assert property (ret_arith_s ##0 (denormals_to_zero_bit && ret.swc) |=> !res.denorm_trap)
      else $error("denormal trapped under zero mode");
   nonarith_a: assert property (ret.valid && !ret.arith
      |=> !res.trap && res.value == $past(ret.dp_result))
      else $error("non-arithmetic op altered or trapped");
   snan_quiet_a: assert property (ret_arith_s ##0 ret.add_sub && ret.swc && a_snan
      |=> res.value[51] && (ctrl_q[8] || $past(ret.ctrl_write)))
      else $error("signaling NaN not quieted");
   suppress_a: assert property (ret_arith_s ##0 (ret.swc && dis_bits[2] && exc[2])
      |=> !res.trap_exc[2])
      else $error("disabled overflow still trapped");
   imb_open_a: assert property (issue_valid && d_fw && fw_fn == 26'h86
      |=> dec.instruction_memory_barrier_call && !dec.priv_fault)
      else $error("barrier call flagged privileged");
   indep_flag_a: assert property (issue_valid && issue_instr[31:26] == 6'h17
      |=> dec.flt_indep)
      else $error("independent opcode missed");
   sqrt_dec_a: assert property (issue_valid && opc == 6'h16 && fn[5:0] == 6'h2B
      |=> dec.sqrt_hw)
      else $error("double root not decoded");
   canon_nan_a: assert property (ret_arith_s ##0 special && inf_inf && !any_nan
      |=> res.value == 64'h7FF8_0000_0000_0000)
      else $error("canonical quiet NaN missing");
   inf_pass_a: assert property (ret_arith_s ##0 special && !any_nan && !inf_inf
      |=> res.value[62:0] == 63'h7FF0_0000_0000_0000 && res.trap_exc == 5'h0)
      else $error("infinite input not passed");
   inv_subst_a: assert property (ret_arith_s ##0 !special && exc == 5'h01 && dis_eff[0]
      |=> res.value == 64'h7FF8_0000_0000_0000 && !res.trap_exc[0])
      else $error("invalid substitute wrong");
   ovf_subst_a: assert property (ret_arith_s ##0 exc == 5'h04 && dis_eff[2]
      |=> res.value[63] == $past(ret.dp_result[63]) && res.value[62:0] == ($past(ret.ovf_to_max)
      ? 63'h7FEF_FFFF_FFFF_FFFF : 63'h7FF0_0000_0000_0000))
      else $error("overflow substitute wrong");
   dis_notrap_a: assert property (ret_arith_s ##0 (exc & dis_eff) != 5'h0
      |=> (res.trap_exc & $past(exc & dis_eff)) == 5'h0)
      else $error("disabled exception trapped");
   sum_set_a: assert property (ret.valid ##0 (|trap_exc)
      |=> res.trap && (sum_q[4:0] & $past(trap_exc)) == $past(trap_exc))
      else $error("trap not in summary");
   trap_irq_a: assert property (ret.valid ##0 (|trap_exc)
      |=> istat_q[0])
      else $error("arithmetic trap not raised");
   den_sum_a: assert property (ret.valid ##0 den_trap
      |=> sum_q[5] && istat_q[1])
      else $error("denormal trap not recorded");
   stat_retire_a: assert property (!ret.valid && !(wr_acc && sel_ctrl)
      |=> $stable(ctrl_q))
      else $error("control register moved off retire");
endmodule // fpx_unit

// ---- testbench/fpx_pipe_model.sv ----
`timescale 1ns/100ps
module fpx_pipe_model (
   input  wire logic            pclk,        // Core clock
   output logic                 issue_valid, // Instruction offered
   output logic [31:0]          issue_instr, // Instruction word
   output logic                 kernel_mode, // Privileged context
   output fpx_pkg::fpx_retire_t ret          // Retiring instruction
);
   initial begin
      issue_valid = 1'h0;
      issue_instr = 32'h0;
      kernel_mode = 1'h0;
      ret = '0;
   end
   task automatic issue(input logic [31:0] w, input logic k);
      @(posedge pclk);
      issue_valid <= 1'h1;
      issue_instr <= w;
      kernel_mode <= k;
      @(posedge pclk);
      issue_valid <= 1'h0;
      issue_instr <= ~w;
   endtask
   // Released retire fields stay busy so a missing valid qualifier shows up
   task automatic retire(input fpx_pkg::fpx_retire_t r);
      @(posedge pclk);
      ret <= r;
      @(posedge pclk);
      ret <= {1'h0, ~r[$bits(r)-2:0]};
   endtask
endmodule // fpx_pipe_model

// ---- testbench/tb_fpx_unit.sv ----
`timescale 1ns/100ps
module tb_fpx_unit;
   logic                 pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0;
   logic                 pwrite = 1'h0, pready, pslverr, irq, issue_valid, kernel_mode, e;
   logic [31:0]          paddr = 32'h0, pwdata = 32'h0, prdata, q, w, issue_instr, ctrl_value;
   logic [31:0]          seed = 32'h0001_1702;
   logic [63:0]          r;
   logic [70:0]          eq[$], cq[$], c;
   fpx_pkg::fpx_decode_t dec;
   fpx_pkg::fpx_retire_t ret;
   fpx_pkg::fpx_result_t res;
   int                   errors = 0, num_checks = 0;
   localparam logic [63:0] PI = 64'h7FF0_0000_0000_0000, DN = 64'h1;
   localparam logic [63:0] SN = 64'h7FF0_0000_0000_0001, CQ = fpx_pkg::CANON_QNAN;
   // Entry: instruction, kernel mode, decode bit index, expected bit
   localparam logic [37:0] DT [15] = '{
      {32'h5C000400, 1'h0, 4'hD, 1'h1}, {32'h5C000480, 1'h0, 4'hC, 1'h1},
      {32'h5C0004A0, 1'h0, 4'hB, 1'h1}, {32'h5C000440, 1'h0, 4'hE, 1'h1},
      {32'h00000000, 1'h0, 4'h2, 1'h1}, {32'h00000000, 1'h1, 4'h2, 1'h0},
      {32'h00000000, 1'h1, 4'h5, 1'h1}, {32'h00000086, 1'h0, 4'h3, 1'h1},
      {32'h00000086, 1'h0, 4'h2, 1'h0}, {32'h60000000, 1'h0, 4'h1, 1'h1},
      {32'h54000140, 1'h0, 4'h7, 1'h1}, {32'h54001540, 1'h0, 4'h7, 1'h1},
      {32'h5800B160, 1'h0, 4'h7, 1'h1}, {32'h5800B560, 1'h0, 4'h7, 1'h1},
      {32'h44000C20, 1'h0, 4'h0, 1'h1}};
   always #5 pclk = ~pclk;
   fpx_unit u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .irq, .issue_valid, .issue_instr, .kernel_mode, .dec, .ret, .res,
      .ctrl_value);
   fpx_pipe_model u_pipe (.pclk, .issue_valid, .issue_instr, .kernel_mode, .ret);
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   task automatic chk(input string n, input logic [70:0] s, x);
      num_checks++;
      if (s !== x) begin
         errors++;
         $display("mismatch %s expected %h seen %h", n, x, s);
      end
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic apb(input logic wr, input logic [31:0] a, d);
      @(posedge pclk);
      psel <= 1'h1;
      penable <= 1'h0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      do @(posedge pclk); while (pready !== 1'h1);
      q = prdata;
      e = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask
   task automatic rd(input logic [31:0] a, x, input logic xe);
      apb(1'h0, a, 32'h0);
      chk("prdata", q, x);
      chk("pslverr", e, xe);
   endtask
   // Flags: trap, denormal trap, trapped exceptions; tc and vc mark trap and value as checked
   task automatic rt(input logic [9:0] f, input logic [4:0] x, input logic [63:0] a, b, v,
                     input logic [6:0] ef, input logic tc, vc);
      fpx_pkg::fpx_retire_t rr;
      rr = '0;
      rr.valid = 1'h1;
      {rr.arith, rr.add_sub, rr.subtract, rr.swc, rr.ovf_to_max, rr.trap_en} = f;
      rr.dp_exc = x;
      rr.op_a = a;
      rr.op_b = b;
      rr.dp_result = (a == DN && f == 10'h0) ? DN : r;
      eq.push_back({ef, v});
      cq.push_back({tc, 6'h3F, {64{vc}}});
      u_pipe.retire(rr);
   endtask
   always @(posedge pclk) if (res.valid === 1'h1) begin
      c = cq.pop_front();
      chk("res", {res.trap, res.denorm_trap, res.trap_exc, res.value} & c, eq.pop_front() & c);
   end
   initial begin
      repeat (5) @(posedge pclk);
      presetn <= 1'h1;
      rd(32'h0, 32'h0, 1'h0);
      rd(32'h10, 32'h200, 1'h0);
      rd(32'h40, 32'h0, 1'h1);
      $display("test apb done");
      foreach (DT[i]) begin
         w = DT[i][37:6] | ((DT[i][37:32] != 6'h0) ? (xs() & 32'h03FF_0000) : 32'h0);
         u_pipe.issue(w, DT[i][5]);
         #1 chk("dec", dec[DT[i][4:1]], DT[i][0]);
      end
      $display("test decode done");
      r = {xs(), xs()};
      r[63:52] = 12'h400;
      rt(10'h25F, 5'h04, DN, 64'h0, 64'h0, 7'h60, 1'h1, 1'h0);
      rt(10'h25F, 5'h04, 64'h0, 64'h0, 64'h0, 7'h44, 1'h1, 1'h0);
      rt(10'h000, 5'h00, DN, 64'h0, DN, 7'h00, 1'h1, 1'h1);
      rd(32'h4, 32'h24, 1'h0);
      apb(1'h1, 32'hC, 32'h3);
      #1 chk("irq", irq, 1'h1);
      rd(32'h8, 32'h3, 1'h0);
      #1 chk("irq", irq, 1'h0);
      apb(1'h1, 32'h0, 32'h7F);
      rt(10'h25F, 5'h00, DN, 64'h0, r, 7'h00, 1'h1, 1'h1);
      r[63] = 1'h1;
      rt(10'h25F, 5'h04, 64'h0, 64'h0, {1'h1, fpx_pkg::INF_MAG}, 7'h0, 1'h1, 1'h1);
      rt(10'h27F, 5'h04, 64'h0, 64'h0, {1'h1, fpx_pkg::MAX_MAG}, 7'h0, 1'h1, 1'h1);
      r[63] = 1'h0;
      rt(10'h25F, 5'h02, 64'h0, 64'h0, PI, 7'h00, 1'h1, 1'h1);
      rt(10'h25F, 5'h01, 64'h0, 64'h0, CQ, 7'h00, 1'h1, 1'h1);
      rt(10'h25F, 5'h08, 64'h0, 64'h0, 64'h0, 7'h00, 1'h1, 1'h1);
      rt(10'h3DF, 5'h00, PI, PI, CQ, 7'h00, 1'h1, 1'h1);
      rt(10'h35F, 5'h00, SN, 64'h0, SN | fpx_pkg::QUIET_MASK, 7'h0, 1'h1, 1'h1);
      rt(10'h35F, 5'h00, PI, 64'h0, PI, 7'h00, 1'h1, 1'h1);
      rd(32'h0, 32'hF7F, 1'h0);
      rd(32'h0, 32'hF7F, 1'h0);
      chk("ctrl_value", ctrl_value, 32'hF7F);
      apb(1'h1, 32'h0, 32'h0);
      rd(32'h0, 32'h0, 1'h0);
      chk("pending", eq.size(), 0);
      $display("test retire done");
      report_and_stop();
   end
   initial begin
      #100000;
      errors++;
      report_and_stop();
   end
endmodule // tb_fpx_unit
